/* File: dv/srm_mcu_model.sv */
`default_nettype none
// ----------------------------------------
// Microcontroller side: SPI master, mode 0
// ----------------------------------------
module srm_mcu_model (
   output logic spi_clk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle: clock low, deselected
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // msb first, sampled before each rise
   task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      cs_n = 1'b0;
      #337;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = tx[i];
         #80;
         rx[i] = miso;
         spi_clk = 1'b1;
         #80;
         spi_clk = 1'b0;
      end
      #80;
      cs_n = 1'b1;
      mosi = ~mosi; // Released line shows no stale bit
   endtask
endmodule // srm_mcu_model
`default_nettype wire

/* File: dv/srm_top_properties.sv */
`default_nettype none
// ----------------------------------------
// Port checks for the status readback block
// ----------------------------------------
module srm_top_properties (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic miso_oe_n,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_sel,
   input wire logic cmd_wd,
   input wire logic cmd_switch_on,
   input wire logic direct_drive_on,
   input wire logic oc_high_in,
   input wire logic current_sense_enable,
   input wire logic spi_output_on,
   input wire logic oc_high_thr,
   input wire logic [2:0] oc_low_thr,
   input wire logic [3:0] direct_drive_ctrl_reg,
   input wire logic fault_status_pin,
   input wire logic frame_done,
   input wire logic [7:0] status_byte
);
   logic [7:0] dd_hist_r;
   logic last_wd_r;
   logic [2:0] last_sel_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Last committed command, recent direct drive
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dd_hist_r <= 8'h00;
         last_wd_r <= 1'b0;
         last_sel_r <= srm_pkg::SEL_RESET;
      end else begin
         dd_hist_r <= {dd_hist_r[6:0], direct_drive_on};
         if (frame_done) last_wd_r <= cmd_wd;
         if (frame_done && cmd_valid) last_sel_r <= cmd_sel;
      end
   end
   a_oe_tracks_cs:
      assert property (miso_oe_n == cs_n) else $error("miso enable differs from chip select");
   a_done_single:
      assert property (frame_done |=> !frame_done) else $error("frame_done longer than one cycle");
   a_done_cs_high:
      assert property (frame_done |-> cs_n && $past(cs_n, 2)) else $error("frame_done without closed frame");
   a_wd_echo:
      assert property (!cs_n [*7] |-> status_byte[7] == last_wd_r) else $error("top bit not the watchdog bit");
   a_null_sel:
      assert property (!cs_n [*7] |-> last_sel_r != srm_pkg::SEL_NULL || status_byte[2:0] == 3'h0)
      else $error("null selection not zero");
   a_outcfg_sel:
      assert property (!cs_n [*7] ##0 last_sel_r == srm_pkg::SEL_OUTCFG
         |-> status_byte[1:0] == {current_sense_enable, spi_output_on}) else $error("output config wrong");
   a_octhr_sel:
      assert property (!cs_n [*7] ##0 last_sel_r == srm_pkg::SEL_OCTHR
         |-> status_byte[3:0] == {oc_high_thr, oc_low_thr}) else $error("threshold readback wrong");
   a_drive_sel:
      assert property (!cs_n [*7] ##0 last_sel_r == srm_pkg::SEL_DRIVE
         |-> status_byte[3:0] == direct_drive_ctrl_reg) else $error("drive register readback wrong");
   a_fault_set:
      assert property ($rose(oc_high_in) |-> ##[1:8] fault_status_pin) else $error("fault pin not raised");
   a_fault_hold:
      assert property ($fell(fault_status_pin) |-> $past(cmd_switch_on) || (|dd_hist_r))
      else $error("fault pin released without switch-on");
   c_fault_release: cover property ($fell(fault_status_pin));
   c_commit: cover property (frame_done && cmd_valid);
   c_drive_sel: cover property (frame_done && cmd_sel == srm_pkg::SEL_DRIVE);
endmodule // srm_top_properties
`default_nettype wire

/* File: dv/tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_n, spi_clk, cs_n, mosi, miso, miso_oe_n, frame_done, fault_status_pin;
   logic cmd_valid, cmd_extra, cmd_wd, cmd_switch_on, direct_drive_on, oc_high_in, oc_low_in;
   logic overtemp_in, open_load_in, undervoltage_in, overvoltage_in;
   logic current_sense_enable, spi_output_on, oc_high_thr, oc_timeout_active, open_load_active;
   logic failsafe_output_state, watchdog_expired, direct_drive_pin, failsafe_strap_lead, wake_pin;
   logic [2:0] cmd_sel, oc_low_thr, turn_on_delay_reg;
   logic [1:0] oc_blank_time, watchdog_timeout_reg, supply_protect_reg;
   logic [3:0] direct_drive_ctrl_reg;
   logic [7:0] status_byte;
   logic [15:0] rx;
   int errors, checks, dones;
   // Sel, extra, expected low nibble, mask; entry 0 is the reset state
   logic [11:0] tbl [10] = '{12'hE07, 12'h223, 12'h4DF, 12'h66F, 12'h8AF, 12'hABF, 12'hB57, 12'hC57,
      12'hD23, 12'hE07};
   srm_top i_srm_top (.sys_clk, .rst_n, .spi_clk, .cs_n, .mosi, .miso, .miso_oe_n, .cmd_valid, .cmd_sel,
      .cmd_extra, .cmd_wd, .cmd_switch_on, .direct_drive_on, .overtemp_in, .oc_high_in, .oc_low_in,
      .open_load_in, .undervoltage_in, .overvoltage_in, .current_sense_enable, .spi_output_on, .oc_high_thr,
      .oc_low_thr, .oc_blank_time, .oc_timeout_active, .open_load_active, .direct_drive_ctrl_reg,
      .turn_on_delay_reg, .failsafe_output_state, .watchdog_timeout_reg, .watchdog_expired,
      .supply_protect_reg, .direct_drive_pin, .failsafe_strap_lead, .wake_pin, .fault_status_pin,
      .frame_done, .status_byte);
   srm_mcu_model i_srm_mcu_model (.spi_clk, .cs_n, .mosi, .miso);
   // 25 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   // Decoded command stands through the frame and its commit
   task automatic frame(input int n, input logic [3:0] se, input logic wd, input logic on);
      {cmd_sel, cmd_extra} = se;
      cmd_wd = wd;
      cmd_switch_on = on;
      cmd_valid = ~on;
      i_srm_mcu_model.xfer(n, {8'h5A, wd, 4'h0, se[3:1]}, rx);
      dones = 0;
      repeat (12) begin
         @(posedge sys_clk);
         #2;
         dones += frame_done;
      end
      check("frame_done", 8'(dones), (n % 8 == 0) ? 8'h01 : 8'h00);
   endtask
   task automatic expect_low(input logic [6:0] exp, input logic [6:0] mask);
      check("miso_low", {1'b0, rx[6:0] & mask}, {1'b0, exp});
      check("status_low", {1'b0, status_byte[6:0] & mask}, {1'b0, exp});
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {cmd_valid, cmd_extra, cmd_wd, cmd_switch_on, cmd_sel, direct_drive_on, oc_high_in, oc_low_in} = '0;
      {overtemp_in, open_load_in, undervoltage_in, overvoltage_in} = 4'h0;
      // Configuration levels behind the table expectations
      {current_sense_enable, spi_output_on, oc_high_thr, oc_low_thr} = 6'h2D;
      {oc_blank_time, oc_timeout_active, open_load_active} = 4'hA;
      {direct_drive_ctrl_reg, failsafe_output_state, turn_on_delay_reg} = 8'hAB;
      {watchdog_expired, watchdog_timeout_reg, supply_protect_reg} = 5'h16;
      {direct_drive_pin, failsafe_strap_lead, wake_pin} = 3'h5;
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(4);
      // Each frame commits one selection and reads back the one before
      for (int i = 1; i < 10; i++) begin
         frame(8, tbl[i][11:8], i[0], 1'b0);
         expect_low({3'h0, tbl[i-1][7:4]}, {3'h0, tbl[i-1][3:0]});
         if (i > 1) check("wd_echo", {7'h00, rx[7]}, {7'h00, ~i[0]});
      end
      $display("test selection table done");
      frame(7, 4'h2, 1'b0, 1'b0);
      frame(15, 4'h2, 1'b0, 1'b0);
      frame(8, 4'h0, 1'b0, 1'b0);
      expect_low(7'h00, 7'h07);
      check("wd_after_short", {7'h00, rx[7]}, 8'h01);
      $display("test short frame done");
      oc_high_in = 1'b1;
      oc_low_in = 1'b1;
      tick(4);
      oc_high_in = 1'b0;
      oc_low_in = 1'b0;
      tick(8);
      check("fault_pin_set", {7'h00, fault_status_pin}, 8'h01);
      frame(8, 4'h0, 1'b0, 1'b0);
      expect_low(7'h31, 7'h7F);
      frame(8, 4'h0, 1'b0, 1'b0);
      expect_low(7'h00, 7'h7F);
      check("fault_pin_held", {7'h00, fault_status_pin}, 8'h01);
      frame(8, 4'h0, 1'b0, 1'b1);
      check("fault_pin_spi_off", {7'h00, fault_status_pin}, 8'h00);
      oc_low_in = 1'b1;
      tick(4);
      oc_low_in = 1'b0;
      tick(8);
      check("fault_pin_again", {7'h00, fault_status_pin}, 8'h01);
      direct_drive_on = 1'b1;
      tick(4);
      direct_drive_on = 1'b0;
      tick(8);
      check("fault_pin_drive_off", {7'h00, fault_status_pin}, 8'h00);
      $display("test fault flags done");
      frame(16, 4'h0, 1'b1, 1'b0);
      check("echo_byte", rx[7:0], 8'h5A);
      $display("test echo done");
      complete_run();
   end
   // Hang guard, well beyond the expected run
   initial begin
      #200000;
      errors++;
      complete_run();
   end
endmodule // tb_top
bind srm_top srm_top_properties i_srm_top_properties (.sys_clk, .rst_n, .cs_n, .miso_oe_n, .cmd_valid,
   .cmd_sel, .cmd_wd, .cmd_switch_on, .direct_drive_on, .oc_high_in, .current_sense_enable, .spi_output_on,
   .oc_high_thr, .oc_low_thr, .direct_drive_ctrl_reg, .fault_status_pin, .frame_done, .status_byte);
`default_nettype wire

/* File: rtl/srm_link.sv */
`default_nettype none
// SPI-clock side shifter: loads, shifts, counts, and hands a finished word across
module srm_link (
   spi_clk,
   rst_n,
   cs_n,
   mosi,
   load_byte,
   miso,
   miso_oe_n,
   rx_byte,
   rx_toggle,
   rx_count_ok
);
   input wire logic spi_clk;
   input wire logic rst_n;
   input wire logic cs_n;
   input wire logic mosi;
   input wire logic [7:0] load_byte;
   output logic miso;
   output logic miso_oe_n;
   output logic [7:0] rx_byte;
   output logic rx_toggle;
   output logic rx_count_ok;
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] cnt;
      logic loaded;
   } srm_link_st_t;
   typedef struct packed {
      logic [7:0] rx;
      logic tgl;
      logic ok;
   } srm_link_hold_t;
   srm_link_st_t st_r;
   srm_link_st_t st_nxt;
   srm_link_hold_t hd_r;
   srm_link_hold_t hd_nxt;
   // Shift in on rising edge; chip select high resets the shifter while idle
   always_comb begin
      st_nxt = st_r;
      hd_nxt = hd_r;
      if (!st_r.loaded) begin
         st_nxt.sh = {load_byte[6:0], mosi};
         st_nxt.loaded = 1'b1;
      end else begin
         st_nxt.sh = {st_r.sh[6:0], mosi};
      end
      st_nxt.cnt = st_r.cnt + 3'h1;
      // length flag kept past chip select rise
      hd_nxt.ok = (st_nxt.cnt == 3'h0);
      if (st_r.cnt == srm_pkg::BIT_LAST) begin
         hd_nxt.rx = st_nxt.sh;
         hd_nxt.tgl = ~hd_r.tgl;
      end
   end
   // Chip select high clears framing state
   always_ff @(posedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   // Received word, event toggle and length flag survive the frame
   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         hd_r <= '0;
      end else begin
         hd_r <= hd_nxt;
      end
   end
   // msb first; first bit shows straight from the loaded byte
   assign miso = st_r.loaded ? st_r.sh[7] : load_byte[7];
   assign miso_oe_n = cs_n;
   assign rx_byte = hd_r.rx;
   assign rx_toggle = hd_r.tgl;
   assign rx_count_ok = hd_r.ok;
endmodule // srm_link
`default_nettype wire

/* File: rtl/srm_pkg.sv */
`default_nettype none
package srm_pkg;
   // ----------------------------------------
   // Readback selection codes
   // ----------------------------------------
   localparam logic [2:0] SEL_FAULT = 3'h0;
   localparam logic [2:0] SEL_OUTCFG = 3'h1;
   localparam logic [2:0] SEL_OCTHR = 3'h2;
   localparam logic [2:0] SEL_OCTIME = 3'h3;
   localparam logic [2:0] SEL_DRIVE = 3'h4;
   localparam logic [2:0] SEL_DELAY_WD = 3'h5;
   localparam logic [2:0] SEL_PINS_SUP = 3'h6;
   localparam logic [2:0] SEL_NULL = 3'h7;
   localparam logic [2:0] SEL_RESET = 3'h7;
   // ----------------------------------------
   // Fault flag positions
   // ----------------------------------------
   localparam int FB_OT = 6;
   localparam int FB_OCH = 5;
   localparam int FB_OCL = 4;
   localparam int FB_OL = 3;
   localparam int FB_UV = 2;
   localparam int FB_OV = 1;
   localparam int FB_SUM = 0;
   // ----------------------------------------
   // Byte framing
   // ----------------------------------------
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [6:0] NULL_LOW = 7'h00;
endpackage : srm_pkg
`default_nettype wire

/* File: rtl/srm_sync.sv */
`default_nettype none
// Two-flop synchroniser for a level
module srm_sync #(
   parameter int W = 1
) (
   clk,
   rst_n,
   d,
   q
);
   input wire logic clk;
   input wire logic rst_n;
   input wire logic [W-1:0] d;
   output logic [W-1:0] q;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } srm_sync_st_t;
   srm_sync_st_t st_r;
   srm_sync_st_t st_nxt;
   // Shift chain
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q = st_r.s2;
endmodule // srm_sync
`default_nettype wire

/* File: rtl/srm_top.sv */
`default_nettype none
// Status readback selector for the switch's serial interface
module srm_top (
   sys_clk,
   rst_n,
   spi_clk,
   cs_n,
   mosi,
   miso,
   miso_oe_n,
   cmd_valid,
   cmd_sel,
   cmd_extra,
   cmd_wd,
   cmd_switch_on,
   direct_drive_on,
   overtemp_in,
   oc_high_in,
   oc_low_in,
   open_load_in,
   undervoltage_in,
   overvoltage_in,
   current_sense_enable,
   spi_output_on,
   oc_high_thr,
   oc_low_thr,
   oc_blank_time,
   oc_timeout_active,
   open_load_active,
   direct_drive_ctrl_reg,
   turn_on_delay_reg,
   failsafe_output_state,
   watchdog_timeout_reg,
   watchdog_expired,
   supply_protect_reg,
   direct_drive_pin,
   failsafe_strap_lead,
   wake_pin,
   fault_status_pin,
   frame_done,
   status_byte
);
   input wire logic sys_clk;
   input wire logic rst_n;
   input wire logic spi_clk;
   input wire logic cs_n;
   input wire logic mosi;
   output logic miso;
   output logic miso_oe_n;
   input wire logic cmd_valid;
   input wire logic [2:0] cmd_sel;
   input wire logic cmd_extra;
   input wire logic cmd_wd;
   input wire logic cmd_switch_on;
   input wire logic direct_drive_on;
   input wire logic overtemp_in;
   input wire logic oc_high_in;
   input wire logic oc_low_in;
   input wire logic open_load_in;
   input wire logic undervoltage_in;
   input wire logic overvoltage_in;
   input wire logic current_sense_enable;
   input wire logic spi_output_on;
   input wire logic oc_high_thr;
   input wire logic [2:0] oc_low_thr;
   input wire logic [1:0] oc_blank_time;
   input wire logic oc_timeout_active;
   input wire logic open_load_active;
   input wire logic [3:0] direct_drive_ctrl_reg;
   input wire logic [2:0] turn_on_delay_reg;
   input wire logic failsafe_output_state;
   input wire logic [1:0] watchdog_timeout_reg;
   input wire logic watchdog_expired;
   input wire logic [1:0] supply_protect_reg;
   input wire logic direct_drive_pin;
   input wire logic failsafe_strap_lead;
   input wire logic wake_pin;
   output logic fault_status_pin;
   output logic frame_done;
   output logic [7:0] status_byte;

   // ----------------------------------------
   // Reset release and input crossing
   // ----------------------------------------
   typedef struct packed {
      logic s1;
      logic s2;
   } srm_rst_t;
   srm_rst_t rs_r;
   logic rst_sync_n;
   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rs_r <= '0;
      end else begin
         rs_r <= '{s1: 1'b1, s2: rs_r.s1};
      end
   end
   assign rst_sync_n = rs_r.s2;

   logic [2:0] pins_sync;
   logic [6:0] raw_sync;
   logic cs_sync;
   logic tgl_sync;
   logic ok_sync;
   logic [7:0] rx_byte;
   logic rx_tgl;
   logic rx_ok;
   logic link_miso;
   logic link_oe_n;

   // Pin levels sampled twice
   srm_sync #(.W(3)) u_pins (
      .clk(sys_clk),
      .rst_n(rst_sync_n),
      .d({direct_drive_pin, failsafe_strap_lead, wake_pin}),
      .q(pins_sync)
   );
   // Fault sources from the analog side and the direct drive input
   srm_sync #(.W(7)) u_raw (
      .clk(sys_clk),
      .rst_n(rst_sync_n),
      .d({overtemp_in, oc_high_in, oc_low_in, open_load_in, undervoltage_in, overvoltage_in, direct_drive_on}),
      .q(raw_sync)
   );
   // Link-side signals crossing back
   srm_sync #(.W(3)) u_lnk (
      .clk(sys_clk),
      .rst_n(rst_sync_n),
      .d({cs_n, rx_tgl, rx_ok}),
      .q({cs_sync, tgl_sync, ok_sync})
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] sel;
      logic extra;
      logic wd;
      logic [6:0] flags;
      logic fs;
      logic cs_d;
      logic tgl_d;
      logic got_byte;
      logic drv_d;
      logic [7:0] snap;
      logic done;
   } srm_st_t;
   srm_st_t st_r;
   srm_st_t st_nxt;

   // Low seven bits of the returned word for a selection
   function automatic logic [6:0] pick_low(input logic [2:0] sel, input logic extra, input logic [6:0] flt,
                                          input logic [2:0] pins);
      logic [6:0] r;
      r = srm_pkg::NULL_LOW;
      case (sel)
         srm_pkg::SEL_FAULT: r = flt;
         srm_pkg::SEL_OUTCFG: r = {3'h1, 2'h0, current_sense_enable, spi_output_on};
         srm_pkg::SEL_OCTHR: r = {3'h2, oc_high_thr, oc_low_thr};
         srm_pkg::SEL_OCTIME: r = {3'h3, open_load_active, oc_timeout_active, oc_blank_time};
         srm_pkg::SEL_DRIVE: r = {3'h4, direct_drive_ctrl_reg};
         srm_pkg::SEL_DELAY_WD: begin
            if (extra) begin
               r = {3'h5, 1'b0, watchdog_expired, watchdog_timeout_reg};
            end else begin
               r = {3'h5, failsafe_output_state, turn_on_delay_reg};
            end
         end
         srm_pkg::SEL_PINS_SUP: begin
            if (extra) begin
               r = {3'h6, 2'h0, supply_protect_reg};
            end else begin
               r = {3'h6, 1'b0, pins};
            end
         end
         srm_pkg::SEL_NULL: r = srm_pkg::NULL_LOW;
         default: r = srm_pkg::NULL_LOW;
      endcase
      return r;
   endfunction

   logic [6:0] live_faults;
   logic any_fault;
   logic cs_fall;
   logic cs_rise;
   logic valid_end;

   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.cs_d = cs_sync;
      st_nxt.tgl_d = tgl_sync;
      st_nxt.drv_d = raw_sync[0];
      st_nxt.done = 1'b0;
      cs_fall = st_r.cs_d & ~cs_sync;
      cs_rise = ~st_r.cs_d & cs_sync;
      valid_end = cs_rise & ok_sync & st_r.got_byte;
      any_fault = |raw_sync[6:1];
      live_faults = {raw_sync[6], st_r.flags[srm_pkg::FB_OCH], st_r.flags[srm_pkg::FB_OCL], raw_sync[3],
                     raw_sync[2], raw_sync[1], st_r.flags[srm_pkg::FB_SUM]};
      if (cs_fall) begin
         st_nxt.snap = {st_r.wd, pick_low(st_r.sel, st_r.extra, live_faults, pins_sync)};
         st_nxt.got_byte = 1'b0;
         if (st_r.sel == srm_pkg::SEL_FAULT) begin
            st_nxt.flags[srm_pkg::FB_SUM] = 1'b0;
            st_nxt.flags[srm_pkg::FB_OCH] = 1'b0;
            st_nxt.flags[srm_pkg::FB_OCL] = 1'b0;
         end
      end
      if (tgl_sync != st_r.tgl_d) begin
         st_nxt.got_byte = 1'b1;
      end
      if (raw_sync[5]) begin
         st_nxt.flags[srm_pkg::FB_OCH] = 1'b1;
      end
      if (raw_sync[4]) begin
         st_nxt.flags[srm_pkg::FB_OCL] = 1'b1;
      end
      if (any_fault) begin
         st_nxt.flags[srm_pkg::FB_SUM] = 1'b1;
      end
      if (valid_end) begin
         st_nxt.done = 1'b1;
         st_nxt.wd = cmd_wd;
         if (cmd_valid) begin
            st_nxt.sel = cmd_sel;
            st_nxt.extra = cmd_extra;
         end
      end
      if ((valid_end & cmd_switch_on) | (raw_sync[0] & ~st_r.drv_d)) begin
         st_nxt.fs = 1'b0;
      end
      if (any_fault) begin
         st_nxt.fs = 1'b1;
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_r <= '{sel: srm_pkg::SEL_RESET, cs_d: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Link side
   // ----------------------------------------
   srm_link u_link (
      .spi_clk(spi_clk),
      .rst_n(rst_sync_n),
      .cs_n(cs_n),
      .mosi(mosi),
      .load_byte(st_r.snap),
      .miso(link_miso),
      .miso_oe_n(link_oe_n),
      .rx_byte(rx_byte),
      .rx_toggle(rx_tgl),
      .rx_count_ok(rx_ok)
   );

   assign miso = link_miso;
   assign miso_oe_n = link_oe_n;
   assign fault_status_pin = st_r.fs;
   assign frame_done = st_r.done;
   assign status_byte = st_r.snap;
endmodule // srm_top
`default_nettype wire
